// file: rtl/exec_core_pkg.sv
// constants shared by the instruction execution core and its helpers
`default_nettype none
package exec_core_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int FILE_DEPTH = 128;

	// register byte offsets on the bus
	localparam logic [11:0] OFF_COMMAND = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_ACCUM = 12'h008;
	localparam logic [11:0] OFF_PC_HIGH_LATCH = 12'h00C;
	localparam logic [11:0] OFF_PROGRAM_COUNTER = 12'h010;
	localparam logic [11:0] OFF_STACK_TOP = 12'h014;
	localparam logic [11:0] OFF_WATCHDOG = 12'h018;
	// file registers: base plus four times the 7-bit file address
	localparam logic [11:0] OFF_FILE_BASE = 12'h200;

	// command word fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_OP_W = 3;
	localparam int CMD_DEST_BIT = 3;
	localparam int CMD_FILE_LSB = 4;
	localparam int CMD_FILE_W = 7;

	// status word fields
	localparam int ST_ZERO_BIT = 0;
	localparam int ST_TIMEOUT_N_BIT = 1;
	localparam int ST_POWERDOWN_N_BIT = 2;
	localparam int ST_BUSY_BIT = 3;

	// watchdog word fields
	localparam int WD_COUNT_LSB = 0;
	localparam int WD_PRESCALE_LSB = 8;

	// reset values
	localparam logic RST_ZERO = 1'b0;
	localparam logic RST_TIMEOUT_N = 1'b1;
	localparam logic RST_POWERDOWN_N = 1'b1;
	localparam logic [7:0] RST_ACCUM = 8'h00;
	localparam logic [6:0] RST_PC_HIGH_LATCH = 7'h00;
	localparam logic [14:0] RST_PROGRAM_COUNTER = 15'h0000;
	localparam logic [14:0] RST_STACK_TOP = 15'h0000;
	localparam logic [7:0] RST_WATCHDOG = 8'h00;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		OP_NOP = 3'h0,
		OP_CALL_VIA_ACCUMULATOR = 3'h1,
		OP_CLEAR_FILE_REGISTER = 3'h2,
		OP_CLEAR_ACCUMULATOR = 3'h3,
		OP_RESTART_WATCHDOG = 3'h4,
		OP_COMPLEMENT_REGISTER = 3'h5,
		OP_DECREMENT_REGISTER = 3'h6
	} opcode_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_CALL_LOAD = 3'b100
	} core_state_e;
endpackage : exec_core_pkg
`default_nettype wire

// file: rtl/file_op_if.sv
// carrier between the core and its complement / decrement unit
`default_nettype none
interface file_op_if;
	logic [7:0] operand;
	logic decrement;
	logic [7:0] result;
	logic zero;
	modport core (output operand, output decrement, input result,
		input zero);
	modport unit (input operand, input decrement, output result,
		output zero);
endinterface : file_op_if
`default_nettype wire

// file: rtl/file_op_unit.sv
// complement or decrement of one file register value with zero detect
`default_nettype none
module file_op_unit (
	file_op_if.unit op
);
	always_comb begin
		if (op.decrement) begin
			op.result = op.operand - 8'h01;
		end else begin
			op.result = ~op.operand;
		end
		op.zero = (op.result == 8'h00);
	end
endmodule : file_op_unit
`default_nettype wire

// file: rtl/exec_core.sv
// instruction execution core with an axi4-lite register slave
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`default_nettype none
module exec_core (
	input wire logic clock,
	input wire logic rst,
	input wire logic [exec_core_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [exec_core_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [exec_core_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [exec_core_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import exec_core_pkg::*;

	////////////////////////////////////////////////////////////////////
	// state
	core_state_e state, next_state;
	logic [2:0] ins_op, next_ins_op;
	logic ins_dest, next_ins_dest;
	logic [6:0] ins_file, next_ins_file;
	logic [7:0] accum, next_accum;
	logic [6:0] program_counter_high_latch, next_program_counter_high_latch;
	logic [14:0] program_counter, next_program_counter;
	logic [14:0] return_stack_top, next_return_stack_top;
	logic [7:0] watchdog_counter, next_watchdog_counter;
	logic [7:0] watchdog_prescaler, next_watchdog_prescaler;
	logic zero_flag, next_zero_flag;
	logic timeout_status_flag, next_timeout_status_flag;
	logic powerdown_status_flag, next_powerdown_status_flag;

	logic aw_held, next_aw_held;
	logic [ADDR_W-1:0] aw_addr, next_aw_addr;
	logic w_held, next_w_held;
	logic [DATA_W-1:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid;
	logic [1:0] bresp, next_bresp;
	logic rvalid, next_rvalid;
	logic [DATA_W-1:0] rdata, next_rdata;
	logic [1:0] rresp, next_rresp;

	logic [7:0] file_mem [FILE_DEPTH];
	logic mem_we;
	logic [6:0] mem_addr;
	logic [7:0] mem_wdata;

	logic do_write;
	logic [DATA_W-1:0] wr_word;
	logic [DATA_W-1:0] rd_word;
	logic rd_ok;
	logic [31:0] status_word;

	file_op_if alu ();

	file_op_unit u_file_op (
		.op(alu.unit)
	);

	////////////////////////////////////////////////////////////////////
	// bus helpers

	// narrow registers only see the lanes that were strobed
	function automatic logic [31:0] strobe_merge(
		input logic [31:0] old_word,
		input logic [31:0] new_word,
		input logic [3:0] strb
	);
		logic [31:0] merged;
		merged = old_word;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merged[i*8 +: 8] = new_word[i*8 +: 8];
			end
		end
		return merged;
	endfunction : strobe_merge

	function automatic logic is_file_addr(input logic [ADDR_W-1:0] a);
		return (a[ADDR_W-1:9] == OFF_FILE_BASE[ADDR_W-1:9]);
	endfunction : is_file_addr

	assign status_word = {28'h0000000, (state != ST_IDLE),
		powerdown_status_flag, timeout_status_flag, zero_flag};

	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign s_axi_arready = !rvalid;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;

	// read decode, looked up at the address handshake
	always_comb begin
		rd_word = 32'h00000000;
		rd_ok = 1'b1;
		if (is_file_addr(s_axi_araddr)) begin
			rd_word = {24'h000000, file_mem[s_axi_araddr[8:2]]};
		end else begin
			case (s_axi_araddr)
				OFF_COMMAND: rd_word = {21'h000000, ins_file, ins_dest,
					ins_op};
				OFF_STATUS: rd_word = status_word;
				OFF_ACCUM: rd_word = {24'h000000, accum};
				OFF_PC_HIGH_LATCH: rd_word = {25'h0000000,
					program_counter_high_latch};
				OFF_PROGRAM_COUNTER: rd_word = {17'h00000, program_counter};
				OFF_STACK_TOP: rd_word = {17'h00000, return_stack_top};
				OFF_WATCHDOG: rd_word = {16'h0000, watchdog_prescaler,
					watchdog_counter};
				default: rd_ok = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// next-state logic

	// bus writes wait while an instruction runs, so the core never
	// races software for the accumulator, flags or file registers
	assign do_write = aw_held && w_held && !bvalid && (state == ST_IDLE);

	always_comb begin
		next_state = state;
		next_ins_op = ins_op;
		next_ins_dest = ins_dest;
		next_ins_file = ins_file;
		next_accum = accum;
		next_program_counter_high_latch = program_counter_high_latch;
		next_program_counter = program_counter;
		next_return_stack_top = return_stack_top;
		next_zero_flag = zero_flag;
		next_timeout_status_flag = timeout_status_flag;
		next_powerdown_status_flag = powerdown_status_flag;
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		mem_we = 1'b0;
		mem_addr = ins_file;
		mem_wdata = 8'h00;
		wr_word = 32'h00000000;
		alu.operand = file_mem[ins_file];
		alu.decrement = (ins_op == OP_DECREMENT_REGISTER);

		// free-running watchdog stand-in; the restart below overrides it
		next_watchdog_prescaler = watchdog_prescaler + 8'h01;
		next_watchdog_counter = watchdog_counter;
		if (watchdog_prescaler == 8'hFF) begin
			next_watchdog_counter = watchdog_counter + 8'h01;
		end

		// write address and data are taken independently
		if (s_axi_awvalid && !aw_held) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_held) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && !rvalid) begin
			next_rvalid = 1'b1;
			next_rdata = rd_word;
			next_rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end

		case (state)
			ST_IDLE: begin
				if (do_write) begin
					next_aw_held = 1'b0;
					next_w_held = 1'b0;
					next_bvalid = 1'b1;
					next_bresp = RESP_OKAY;
					if (is_file_addr(aw_addr)) begin
						wr_word = strobe_merge({24'h000000,
							file_mem[aw_addr[8:2]]}, w_data, w_strb);
						mem_we = 1'b1;
						mem_addr = aw_addr[8:2];
						mem_wdata = wr_word[7:0];
					end else begin
						case (aw_addr)
							OFF_COMMAND: begin
								wr_word = strobe_merge({21'h000000,
									ins_file, ins_dest, ins_op}, w_data,
									w_strb);
								next_ins_op = wr_word[CMD_OP_LSB +: CMD_OP_W];
								next_ins_dest = wr_word[CMD_DEST_BIT];
								next_ins_file =
									wr_word[CMD_FILE_LSB +: CMD_FILE_W];
								next_state = ST_EXEC;
							end
							OFF_STATUS: begin
								wr_word = strobe_merge(status_word, w_data,
									w_strb);
								next_zero_flag = wr_word[ST_ZERO_BIT];
								next_timeout_status_flag =
									wr_word[ST_TIMEOUT_N_BIT];
								next_powerdown_status_flag =
									wr_word[ST_POWERDOWN_N_BIT];
							end
							OFF_ACCUM: begin
								wr_word = strobe_merge({24'h000000, accum},
									w_data, w_strb);
								next_accum = wr_word[7:0];
							end
							OFF_PC_HIGH_LATCH: begin
								wr_word = strobe_merge({25'h0000000,
									program_counter_high_latch}, w_data,
									w_strb);
								next_program_counter_high_latch =
									wr_word[6:0];
							end
							OFF_PROGRAM_COUNTER: begin
								wr_word = strobe_merge({17'h00000,
									program_counter}, w_data, w_strb);
								next_program_counter = wr_word[14:0];
							end
							OFF_STACK_TOP, OFF_WATCHDOG: begin
								next_bresp = RESP_OKAY;
							end
							default: next_bresp = RESP_SLVERR;
						endcase
					end
				end
			end
			ST_EXEC: begin
				next_state = ST_IDLE;
				next_program_counter = program_counter + 15'h0001;
				case (ins_op)
					OP_CALL_VIA_ACCUMULATOR: begin
						next_return_stack_top =
							program_counter + 15'h0001;
						next_state = ST_CALL_LOAD;
					end
					OP_CLEAR_FILE_REGISTER: begin
						mem_we = 1'b1;
						mem_wdata = 8'h00;
						next_zero_flag = 1'b1;
					end
					OP_CLEAR_ACCUMULATOR: begin
						next_accum = 8'h00;
						next_zero_flag = 1'b1;
					end
					OP_RESTART_WATCHDOG: begin
						next_watchdog_counter = RST_WATCHDOG;
						next_watchdog_prescaler = RST_WATCHDOG;
						next_timeout_status_flag = 1'b1;
						next_powerdown_status_flag = 1'b1;
					end
					OP_COMPLEMENT_REGISTER, OP_DECREMENT_REGISTER: begin
						if (ins_dest) begin
							mem_we = 1'b1;
							mem_wdata = alu.result;
						end else begin
							next_accum = alu.result;
						end
						next_zero_flag = alu.zero;
					end
					default: begin
						next_state = ST_IDLE;
					end
				endcase
			end
			ST_CALL_LOAD: begin
				// second cycle of the call; no flag is written here
				next_program_counter = {program_counter_high_latch,
					accum};
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clock) begin
		if (mem_we) begin
			file_mem[mem_addr] <= mem_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state <= ST_IDLE;
			ins_op <= OP_NOP;
			ins_dest <= 1'b0;
			ins_file <= 7'h00;
			accum <= RST_ACCUM;
			program_counter_high_latch <= RST_PC_HIGH_LATCH;
			program_counter <= RST_PROGRAM_COUNTER;
			return_stack_top <= RST_STACK_TOP;
			watchdog_counter <= RST_WATCHDOG;
			watchdog_prescaler <= RST_WATCHDOG;
			zero_flag <= RST_ZERO;
			timeout_status_flag <= RST_TIMEOUT_N;
			powerdown_status_flag <= RST_POWERDOWN_N;
			aw_held <= 1'b0;
			aw_addr <= 12'h000;
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= RESP_OKAY;
		end else begin
			state <= next_state;
			ins_op <= next_ins_op;
			ins_dest <= next_ins_dest;
			ins_file <= next_ins_file;
			accum <= next_accum;
			program_counter_high_latch <= next_program_counter_high_latch;
			program_counter <= next_program_counter;
			return_stack_top <= next_return_stack_top;
			watchdog_counter <= next_watchdog_counter;
			watchdog_prescaler <= next_watchdog_prescaler;
			zero_flag <= next_zero_flag;
			timeout_status_flag <= next_timeout_status_flag;
			powerdown_status_flag <= next_powerdown_status_flag;
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end
endmodule : exec_core
`default_nettype wire

// file: tb/exec_core_properties.sv
// bus timing properties watched at the execution core ports
`default_nettype none
module exec_core_properties
	import exec_core_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence rd_hole;
		rd_taken ##0 (s_axi_araddr inside {[12'h01C:12'h1FF]});
	endsequence
	a_read_latency: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read answer not one cycle after address");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer changed before taken");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer changed before taken");
	a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while answer pending");
	a_write_early: assert property (wr_taken |=> !s_axi_bvalid)
		else $error("write answer too early");
	// a two cycle call may delay the answer by one cycle
	a_write_bound: assert property (wr_taken |->
		##[2:4] s_axi_bvalid)
		else $error("write answer too late");
	a_slverr_zero: assert property (s_axi_rvalid &&
		s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("error read carries data");
	a_hole_error: assert property (rd_hole |=> s_axi_rresp == RESP_SLVERR)
		else $error("unmapped read not refused");
endmodule : exec_core_properties
bind exec_core exec_core_properties u_props (.clock(clock), .rst(rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// file: tb/exec_core_tb.sv
// self-checking bench for the execution core
`default_nettype none
module exec_core_tb
	import exec_core_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [2:0] op;
		logic d;
		logic [6:0] f;
		logic [7:0] fv, acc, eacc, efv;
		logic [2:0] pst, est;
	} row_s;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	int err_total = 0, n_tests = 0, cycles = 0;
	row_s rows [8];

	always #20 clock = ~clock;

	exec_core DUT (.clock(clock), .rst(rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));

	////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check

	task tally_and_finish;
		if (err_total == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish

	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge clock);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				rs = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask : wr

	task rdr(input logic [11:0] a);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge clock);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				rd = s_axi_rdata;
				rs = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask : rdr

	// whole run needs about a thousand cycles; the ceiling leaves margin
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			err_total++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		rows = '{
			'{3'h5, 1'b0, 7'd5, 8'h3C, 8'h11, 8'hC3, 8'h3C, 3'h1, 3'h0},
			'{3'h5, 1'b1, 7'd127, 8'hFF, 8'h11, 8'h11, 8'h00, 3'h0, 3'h1},
			'{3'h6, 1'b0, 7'd0, 8'h01, 8'h55, 8'h00, 8'h01, 3'h0, 3'h1},
			'{3'h6, 1'b1, 7'd64, 8'h00, 8'h55, 8'h55, 8'hFF, 3'h1, 3'h0},
			'{3'h2, 1'b0, 7'd127, 8'hA5, 8'h66, 8'h66, 8'h00, 3'h0, 3'h1},
			'{3'h3, 1'b0, 7'd3, 8'h12, 8'h7E, 8'h00, 8'h12, 3'h0, 3'h1},
			'{3'h4, 1'b0, 7'd3, 8'h12, 8'h7E, 8'h7E, 8'h12, 3'h0, 3'h6},
			'{3'h7, 1'b1, 7'd3, 8'h12, 8'h7E, 8'h7E, 8'h12, 3'h5, 3'h5}};
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		rdr(OFF_STATUS);
		check(rd, 32'h6);
		rdr(OFF_STACK_TOP);
		check(rd, 32'h0);
		foreach (rows[i]) begin
			wr(OFF_STATUS, {29'h0, rows[i].pst});
			wr(OFF_FILE_BASE + {rows[i].f, 2'b00}, {24'h0, rows[i].fv});
			wr(OFF_ACCUM, {24'h0, rows[i].acc});
			wr(OFF_PROGRAM_COUNTER, 32'h100);
			fork
				wr(OFF_COMMAND, {21'h0, rows[i].f, rows[i].d, rows[i].op});
				begin
					// status is taken two cycles after the command lands
					repeat (3) @(posedge clock);
					rdr(OFF_STATUS);
				end
			join
			check(rd, {29'h0, rows[i].est});
			// bus writes stall until the instruction has finished
			wr(OFF_PC_HIGH_LATCH, 32'h0);
			rdr(OFF_ACCUM);
			check(rd, {24'h0, rows[i].eacc});
			rdr(OFF_FILE_BASE + {rows[i].f, 2'b00});
			check(rd, {24'h0, rows[i].efv});
			rdr(OFF_STATUS);
			check(rd, {29'h0, rows[i].est});
			rdr(OFF_PROGRAM_COUNTER);
			check(rd, 32'h101);
		end
		wr(OFF_PC_HIGH_LATCH, 32'h5A);
		wr(OFF_ACCUM, 32'h3C);
		wr(OFF_PROGRAM_COUNTER, 32'h1234);
		wr(OFF_STATUS, 32'h5);
		fork
			wr(OFF_COMMAND, 32'h1);
			begin
				// a call is still busy in its second cycle
				repeat (3) @(posedge clock);
				rdr(OFF_STATUS);
			end
		join
		check(rd, 32'hD);
		rdr(OFF_STATUS);
		check(rd, 32'h5);
		rdr(OFF_PROGRAM_COUNTER);
		check(rd, 32'h5A3C);
		wr(OFF_COMMAND, 32'h6 | (32'd64 << 4));
		wr(OFF_PC_HIGH_LATCH, 32'h5A);
		rdr(OFF_STACK_TOP);
		check(rd, 32'h1235);
		rdr(OFF_PROGRAM_COUNTER);
		check(rd, 32'h5A3D);
		rdr(OFF_ACCUM);
		check(rd, 32'hFE);
		rdr(OFF_STATUS);
		check(rd, 32'h4);
		// late rready: the read answer must stand until it is taken
		@(posedge clock);
		s_axi_araddr <= OFF_ACCUM;
		s_axi_arvalid <= 1'b1;
		@(posedge clock);
		s_axi_arvalid <= 1'b0;
		repeat (3) @(posedge clock);
		s_axi_rready <= 1'b1;
		@(posedge clock);
		check({31'h0, s_axi_rvalid}, 32'h1);
		check(s_axi_rdata, 32'hFE);
		s_axi_rready <= 1'b0;
		// late bready: the write answer must stand until it is taken
		@(posedge clock);
		s_axi_awaddr <= OFF_PC_HIGH_LATCH;
		s_axi_wdata <= 32'h7F;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		@(posedge clock);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		repeat (3) @(posedge clock);
		s_axi_bready <= 1'b1;
		@(posedge clock);
		check({30'h0, s_axi_bvalid, s_axi_bresp[1]}, 32'h2);
		s_axi_bready <= 1'b0;
		rdr(OFF_PC_HIGH_LATCH);
		check(rd, 32'h7F);
		repeat (600) @(posedge clock);
		rdr(OFF_WATCHDOG);
		check({31'h0, rd[7:0] != 8'h00}, 32'h1);
		wr(OFF_COMMAND, 32'h4);
		rdr(OFF_WATCHDOG);
		check({24'h0, rd[7:0]}, 32'h0);
		check({31'h0, rd[15:8] < 8'h10}, 32'h1);
		rdr(12'h01C);
		check({30'h0, rs}, {30'h0, RESP_SLVERR});
		wr(12'h400, 32'hFF);
		check({30'h0, rs}, {30'h0, RESP_SLVERR});
		wr(OFF_STACK_TOP, 32'h7FFF);
		rdr(OFF_STACK_TOP);
		check(rd, 32'h1235);
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rdr(OFF_PROGRAM_COUNTER);
		check(rd, 32'h0);
		tally_and_finish();
	end
endmodule : exec_core_tb
`default_nettype wire
